// File: hdl/modbus_defines.svh
// shared constants of the modbus rtu slave link
`ifndef MODBUS_DEFINES_SVH
`define MODBUS_DEFINES_SVH

// ----------------------------------------------------------------------
// register port
// ----------------------------------------------------------------------
`define MB_REG_CTRL      4'h0
`define MB_REG_ADDR      4'h1
`define MB_REG_STAT      4'h2
`define MB_REG_MASK      4'h3
`define MB_REG_HIDX      4'h4
`define MB_REG_HDAT      4'h5
`define MB_REG_INFO      4'h6
// ctrl fields: enable, fast rate, parity (2 bits), two stop bits
`define MB_CTRL_EN       0
`define MB_CTRL_FAST     1
`define MB_CTRL_PAR_LO   2
`define MB_CTRL_PAR_HI   3
`define MB_CTRL_STOP2    4
`define MB_CTRL_RST      5'h0b
`define MB_ADDR_RST      8'h01
// status bits
`define MB_ST_DONE       0
`define MB_ST_CRC        1
`define MB_ST_FRM        2
`define MB_ST_REJ        3
// parity codes
`define MB_PAR_NONE      2'h0
`define MB_PAR_ODD       2'h1
// ----------------------------------------------------------------------
// frame and crc
// ----------------------------------------------------------------------
`define MB_CRC_INIT      16'hffff
`define MB_CRC_POLY      16'ha001
`define MB_CRC_RESIDUE   16'h0000
`define MB_CRC_STEPS     8
`define MB_FUNC_READ_HOLD 8'h03
`define MB_QUERY_LEN     4'h8
`define MB_POS_ADDR      7'h0
`define MB_POS_FUNC      7'h1
`define MB_POS_CNT       7'h2
`define MB_HDR_LEN       7'h3
`define MB_OVH_LEN       7'h5
`define MB_CRC_LEN       7'h2
// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define MB_CLK_HZ        250000000
`define MB_BAUD_LO       19200
`define MB_BAUD_HI       38400
// 3.5 characters of 11 bits, rounded up
`define MB_GAP_BITS      6'h27

`endif

// File: hdl/modbus_pkg.sv
// state types of the modbus rtu slave link
package modbus_pkg;
  typedef enum logic [1:0] {ST_COLLECT, ST_EVAL, ST_SEND} link_state_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_t;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_t;
endpackage

// File: hdl/modbus_crc16.sv
// one byte step of the modbus crc-16
`timescale 1ns/1ps
`default_nettype none
`include "modbus_defines.svh"
module modbus_crc16 (
  input  wire logic [15:0] i_crc,
  input  wire logic [7:0]  i_byte,
  output logic      [15:0] o_crc
);
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < `MB_CRC_STEPS; i++) begin
      r = r[0] ? ((r >> 1) ^ `MB_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  assign o_crc = crc_byte(i_crc, i_byte);
endmodule // modbus_crc16
`default_nettype wire

// File: hdl/modbus_uart.sv
// half duplex character engine with frame gap detection
`timescale 1ns/1ps
`default_nettype none
`include "modbus_defines.svh"
module modbus_uart (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic [15:0] i_div,
  input  wire logic [1:0]  i_par,
  input  wire logic        i_two_stop,
  input  wire logic        i_rxd,
  input  wire logic        i_tx_valid,
  input  wire logic [7:0]  i_tx_data,
  output logic             o_rx_valid,
  output logic      [7:0]  o_rx_data,
  output logic             o_rx_err,
  output logic             o_rx_gap,
  output logic             o_tx_ready,
  output logic             o_txd,
  output logic             o_tx_en
);
  modbus_pkg::rx_state_t rx_st_q;
  modbus_pkg::tx_state_t tx_st_q;
  logic [15:0] rx_cnt_q, gap_cnt_q, tx_cnt_q;
  logic [2:0]  rx_bit_q, tx_bit_q;
  logic        rx_perr_q, gap_arm_q, tx_pb_q, tx_stop2_q;
  logic [5:0]  gap_bits_q;
  logic [7:0]  tx_sh_q;

  wire logic rx_tick  = (rx_cnt_q == 16'h0);
  wire logic tx_tick  = (tx_cnt_q == 16'h0);
  wire logic gap_tick = (gap_cnt_q == i_div - 16'h1);
  wire logic par_on   = (i_par != `MB_PAR_NONE);

  function automatic logic par_bit(input logic [7:0] d, input logic [1:0] p);
    return (p == `MB_PAR_ODD) ? ~^d : ^d;
  endfunction

  assign o_tx_ready = (tx_st_q == modbus_pkg::TX_IDLE);

  // ----------------------------------------------------------------------
  // receiver, samples at mid bit
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_st_q    <= modbus_pkg::RX_IDLE;
      rx_cnt_q   <= 16'h0;
      rx_bit_q   <= 3'h0;
      rx_perr_q  <= 1'b0;
      o_rx_data  <= 8'h00;
      o_rx_valid <= 1'b0;
      o_rx_err   <= 1'b0;
    end else begin
      o_rx_valid <= 1'b0;
      rx_cnt_q   <= rx_tick ? i_div - 16'h1 : rx_cnt_q - 16'h1;
      case (rx_st_q)
        modbus_pkg::RX_IDLE: begin
          rx_cnt_q <= i_div >> 1;
          if (!i_rxd) rx_st_q <= modbus_pkg::RX_START;
        end
        modbus_pkg::RX_START: if (rx_tick) begin
          rx_st_q <= i_rxd ? modbus_pkg::RX_IDLE : modbus_pkg::RX_DATA;
        end
        modbus_pkg::RX_DATA: if (rx_tick) begin
          o_rx_data <= {i_rxd, o_rx_data[7:1]};
          rx_bit_q  <= rx_bit_q + 3'h1;
          if (rx_bit_q == 3'h7) rx_st_q <= par_on ? modbus_pkg::RX_PAR : modbus_pkg::RX_STOP;
        end
        modbus_pkg::RX_PAR: if (rx_tick) begin
          rx_perr_q <= (i_rxd != par_bit(o_rx_data, i_par));
          rx_st_q   <= modbus_pkg::RX_STOP;
        end
        modbus_pkg::RX_STOP: if (rx_tick) begin
          o_rx_valid <= 1'b1;
          o_rx_err   <= !i_rxd || rx_perr_q;
          rx_perr_q  <= 1'b0;
          rx_st_q    <= modbus_pkg::RX_IDLE;
        end
        default: rx_st_q <= modbus_pkg::RX_IDLE;
      endcase
    end
  end

  // silence after a character ends the frame
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      gap_arm_q  <= 1'b0;
      gap_cnt_q  <= 16'h0;
      gap_bits_q <= 6'h0;
      o_rx_gap   <= 1'b0;
    end else begin
      o_rx_gap <= 1'b0;
      if (o_rx_valid) gap_arm_q <= 1'b1;
      if (rx_st_q != modbus_pkg::RX_IDLE) begin
        gap_cnt_q  <= 16'h0;
        gap_bits_q <= 6'h0;
      end else if (gap_arm_q) begin
        gap_cnt_q <= gap_tick ? 16'h0 : gap_cnt_q + 16'h1;
        if (gap_tick) gap_bits_q <= gap_bits_q + 6'h1;
        if (gap_bits_q == `MB_GAP_BITS) begin
          o_rx_gap  <= 1'b1;
          gap_arm_q <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // transmitter, drives the line only while a character is out
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_st_q    <= modbus_pkg::TX_IDLE;
      tx_cnt_q   <= 16'h0;
      tx_bit_q   <= 3'h0;
      tx_sh_q    <= 8'h00;
      tx_pb_q    <= 1'b0;
      tx_stop2_q <= 1'b0;
      o_txd      <= 1'b1;
      o_tx_en    <= 1'b0;
    end else begin
      tx_cnt_q <= tx_tick ? i_div - 16'h1 : tx_cnt_q - 16'h1;
      case (tx_st_q)
        modbus_pkg::TX_IDLE: begin
          tx_cnt_q <= i_div - 16'h1;
          if (i_tx_valid) begin
            tx_sh_q <= i_tx_data;
            tx_pb_q <= par_bit(i_tx_data, i_par);
            o_txd   <= 1'b0;
            o_tx_en <= 1'b1;
            tx_st_q <= modbus_pkg::TX_START;
          end
        end
        modbus_pkg::TX_START: if (tx_tick) begin
          o_txd    <= tx_sh_q[0];
          tx_bit_q <= 3'h0;
          tx_st_q  <= modbus_pkg::TX_DATA;
        end
        modbus_pkg::TX_DATA: if (tx_tick) begin
          tx_sh_q  <= tx_sh_q >> 1;
          tx_bit_q <= tx_bit_q + 3'h1;
          o_txd    <= tx_sh_q[1];
          if (tx_bit_q == 3'h7) begin
            o_txd      <= par_on ? tx_pb_q : 1'b1;
            tx_stop2_q <= i_two_stop;
            tx_st_q    <= par_on ? modbus_pkg::TX_PAR : modbus_pkg::TX_STOP;
          end
        end
        modbus_pkg::TX_PAR: if (tx_tick) begin
          o_txd   <= 1'b1;
          tx_st_q <= modbus_pkg::TX_STOP;
        end
        modbus_pkg::TX_STOP: if (tx_tick) begin
          tx_stop2_q <= 1'b0;
          if (!tx_stop2_q) begin
            o_tx_en <= 1'b0;
            tx_st_q <= modbus_pkg::TX_IDLE;
          end
        end
        default: tx_st_q <= modbus_pkg::TX_IDLE;
      endcase
    end
  end
endmodule // modbus_uart
`default_nettype wire

// File: hdl/modbus_rtu_slave_link.sv
// modbus rtu slave link: framing, crc check and function 03 replies
//
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "modbus_defines.svh"
module modbus_rtu_slave_link #(
  parameter int unsigned HOLD_DEPTH = 32,
  parameter int unsigned IDX_W      = 5,
  parameter logic [15:0] DIV_LO     = 16'(`MB_CLK_HZ / `MB_BAUD_LO),
  parameter logic [15:0] DIV_HI     = 16'(`MB_CLK_HZ / `MB_BAUD_HI)
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic [3:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [15:0] o_rdata,
  output logic             o_irq,
  input  wire logic        i_rxd,
  output logic             o_txd,
  output logic             o_tx_en
);

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  modbus_pkg::link_state_t st_q, st_d;
  logic [4:0]       ctrl_q;
  logic [7:0]       slave_q;
  logic [3:0]       stat_q, mask_q, stat_set, stat_d;
  logic [IDX_W-1:0] hidx_q;
  logic [15:0]      hold_q [HOLD_DEPTH];
  logic [7:0]       buf_q [8];
  logic [7:0]       last_q, prev_q;
  logic [3:0]       nbytes_q;
  logic             bad_q;
  logic [15:0]      crc_q, crc_p1_q, crc_p2_q, rx_crc_nxt;
  logic [6:0]       idx_q, len_q;
  logic [15:0]      start_q, tx_crc_q, tx_crc_nxt;
  logic             rx_valid, rx_err, rx_gap, tx_ready;
  logic [7:0]       rx_data;
  logic             tx_valid;
  logic [7:0]       tx_byte;

  // ----------------------------------------------------------------------
  // register port decode
  // ----------------------------------------------------------------------
  wire logic wr_ctrl = i_wr && (i_addr == `MB_REG_CTRL);
  wire logic wr_addr = i_wr && (i_addr == `MB_REG_ADDR);
  wire logic wr_mask = i_wr && (i_addr == `MB_REG_MASK);
  wire logic wr_hidx = i_wr && (i_addr == `MB_REG_HIDX);
  wire logic wr_hdat = i_wr && (i_addr == `MB_REG_HDAT);
  wire logic rd_stat = i_rd && (i_addr == `MB_REG_STAT);

  wire logic [15:0] rd_mux =
    !i_rd                     ? 16'h0000 :
    (i_addr == `MB_REG_CTRL)  ? 16'(ctrl_q) :
    (i_addr == `MB_REG_ADDR)  ? 16'(slave_q) :
    (i_addr == `MB_REG_STAT)  ? 16'(stat_q) :
    (i_addr == `MB_REG_MASK)  ? 16'(mask_q) :
    (i_addr == `MB_REG_HIDX)  ? 16'(hidx_q) :
    (i_addr == `MB_REG_HDAT)  ? hold_q[hidx_q] :
    (i_addr == `MB_REG_INFO)  ? 16'({st_q, nbytes_q}) :
                                16'h0000;

  // ----------------------------------------------------------------------
  // character engine and crc units
  // ----------------------------------------------------------------------
  wire logic [15:0] div = ctrl_q[`MB_CTRL_FAST] ? DIV_HI : DIV_LO;

  modbus_uart u_uart (
    .i_clk      (i_clk),
    .i_rst_n    (i_rst_n),
    .i_div      (div),
    .i_par      (ctrl_q[`MB_CTRL_PAR_HI:`MB_CTRL_PAR_LO]),
    .i_two_stop (ctrl_q[`MB_CTRL_STOP2]),
    .i_rxd      (i_rxd),
    .i_tx_valid (tx_valid),
    .i_tx_data  (tx_byte),
    .o_rx_valid (rx_valid),
    .o_rx_data  (rx_data),
    .o_rx_err   (rx_err),
    .o_rx_gap   (rx_gap),
    .o_tx_ready (tx_ready),
    .o_txd      (o_txd),
    .o_tx_en    (o_tx_en)
  );

  modbus_crc16 u_rx_crc (
    .i_crc  (crc_q),
    .i_byte (rx_data),
    .o_crc  (rx_crc_nxt)
  );

  modbus_crc16 u_tx_crc (
    .i_crc  (tx_crc_q),
    .i_byte (tx_byte),
    .o_crc  (tx_crc_nxt)
  );

  // ----------------------------------------------------------------------
  // query checks
  // ----------------------------------------------------------------------
  wire logic [15:0] q_start = {buf_q[2], buf_q[3]};
  wire logic [15:0] q_qty   = {buf_q[4], buf_q[5]};
  wire logic [16:0] q_end   = 17'(q_start) + 17'(q_qty);

  // check field arrives low byte first
  wire logic crc_ok   = (crc_p2_q == {last_q, prev_q}) && (nbytes_q > 4'h2);
  wire logic addr_ok  = (buf_q[0] == slave_q);
  wire logic func_ok  = (buf_q[1] == `MB_FUNC_READ_HOLD)
                        && (nbytes_q == `MB_QUERY_LEN);
  wire logic range_ok = (q_qty != 16'h0) && (q_end <= 17'(HOLD_DEPTH));
  wire logic eval_en  = (st_q == modbus_pkg::ST_EVAL) && ctrl_q[`MB_CTRL_EN];
  // foreign address and bad crc end silently: no reply at all
  wire logic accept   = eval_en && !bad_q && crc_ok && addr_ok
                        && func_ok && range_ok;

  assign stat_set[`MB_ST_DONE] = (st_q == modbus_pkg::ST_SEND)
                                 && (st_d == modbus_pkg::ST_COLLECT);
  assign stat_set[`MB_ST_CRC]  = eval_en && !bad_q && !crc_ok;
  assign stat_set[`MB_ST_FRM]  = eval_en && bad_q;
  assign stat_set[`MB_ST_REJ]  = eval_en && !bad_q && crc_ok && addr_ok
                                 && !(func_ok && range_ok);
  // set wins over the read clear
  assign stat_d = (stat_q & ~(rd_stat ? 4'hf : 4'h0)) | stat_set;

  // ----------------------------------------------------------------------
  // reply byte selection
  // ----------------------------------------------------------------------
  wire logic [6:0]       dpos     = idx_q - `MB_HDR_LEN;
  wire logic [IDX_W-1:0] widx     = IDX_W'(start_q) + IDX_W'(dpos >> 1);
  wire logic [15:0]      word     = hold_q[widx];
  wire logic [7:0]       cnt_byte = 8'(len_q - `MB_OVH_LEN);
  wire logic             in_data  = idx_q < (len_q - `MB_CRC_LEN);

  // address, function, count, data high first, crc low first
  assign tx_byte = (idx_q == `MB_POS_ADDR)             ? slave_q :
                   (idx_q == `MB_POS_FUNC)             ? `MB_FUNC_READ_HOLD :
                   (idx_q == `MB_POS_CNT)              ? cnt_byte :
                   in_data                             ? (dpos[0] ? word[7:0] : word[15:8]) :
                   (idx_q == len_q - `MB_CRC_LEN)      ? tx_crc_q[7:0] :
                                                         tx_crc_q[15:8];
  assign tx_valid = (st_q == modbus_pkg::ST_SEND) && tx_ready && (idx_q != len_q);

  // ----------------------------------------------------------------------
  // link state machine
  // ----------------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    case (st_q)
      modbus_pkg::ST_COLLECT: if (rx_gap && nbytes_q != 4'h0) st_d = modbus_pkg::ST_EVAL;
      modbus_pkg::ST_EVAL:    st_d = accept ? modbus_pkg::ST_SEND : modbus_pkg::ST_COLLECT;
      modbus_pkg::ST_SEND:    if (tx_ready && idx_q == len_q) st_d = modbus_pkg::ST_COLLECT;
      default:                st_d = modbus_pkg::ST_COLLECT;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) st_q <= modbus_pkg::ST_COLLECT;
    else st_q <= st_d;
  end

  // ----------------------------------------------------------------------
  // frame collection; bytes heard while replying are our own echo
  // ----------------------------------------------------------------------
  wire logic rx_take = rx_valid && (st_q == modbus_pkg::ST_COLLECT);

  always_ff @(posedge i_clk) begin
    if (rx_take && nbytes_q < `MB_QUERY_LEN) buf_q[nbytes_q[2:0]] <= rx_data;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      nbytes_q <= 4'h0;
      bad_q    <= 1'b0;
      last_q   <= 8'h00;
      prev_q   <= 8'h00;
      crc_q    <= `MB_CRC_INIT;
      crc_p1_q <= `MB_CRC_INIT;
      crc_p2_q <= `MB_CRC_INIT;
    end else if (st_q == modbus_pkg::ST_EVAL) begin
      nbytes_q <= 4'h0;
      bad_q    <= 1'b0;
      crc_q    <= `MB_CRC_INIT;
      crc_p1_q <= `MB_CRC_INIT;
      crc_p2_q <= `MB_CRC_INIT;
    end else if (rx_take) begin
      // saturates one past a query so longer frames never match
      if (nbytes_q <= `MB_QUERY_LEN) nbytes_q <= nbytes_q + 4'h1;
      bad_q    <= bad_q | rx_err;
      prev_q   <= last_q;
      last_q   <= rx_data;
      crc_q    <= rx_crc_nxt;
      crc_p1_q <= crc_q;
      crc_p2_q <= crc_p1_q;
    end
  end

  // ----------------------------------------------------------------------
  // reply sequencing
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      idx_q    <= 7'h0;
      len_q    <= 7'h0;
      start_q  <= 16'h0;
      tx_crc_q <= `MB_CRC_INIT;
    end else if (st_q == modbus_pkg::ST_EVAL) begin
      idx_q    <= 7'h0;
      len_q    <= `MB_OVH_LEN + {q_qty[5:0], 1'b0};
      start_q  <= q_start;
      tx_crc_q <= `MB_CRC_INIT;
    end else if (tx_valid) begin
      idx_q <= idx_q + 7'h1;
      if (in_data) tx_crc_q <= tx_crc_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // registers and interrupt
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (wr_hdat) hold_q[hidx_q] <= i_wdata;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_q  <= `MB_CTRL_RST;
      slave_q <= `MB_ADDR_RST;
      mask_q  <= 4'h0;
      hidx_q  <= '0;
      stat_q  <= 4'h0;
      o_rdata <= 16'h0000;
      o_irq   <= 1'b0;
    end else begin
      if (wr_ctrl) ctrl_q <= i_wdata[4:0];
      if (wr_addr) slave_q <= i_wdata[7:0];
      if (wr_mask) mask_q <= i_wdata[3:0];
      if (wr_hidx) hidx_q <= i_wdata[IDX_W-1:0];
      else if (wr_hdat) hidx_q <= hidx_q + IDX_W'(1);
      stat_q  <= stat_d;
      o_rdata <= rd_mux;
      o_irq   <= |(stat_d & mask_q);
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  wire logic go_send = (st_q == modbus_pkg::ST_EVAL) && (st_d == modbus_pkg::ST_SEND);

  a_crc_preset: assert property (
    st_q == modbus_pkg::ST_EVAL |=> crc_q == `MB_CRC_INIT)
    else $error("rx crc not preset after a frame");
  a_crc_residue: assert property (
    go_send |-> crc_q == `MB_CRC_RESIDUE)
    else $error("reply started on a frame with bad crc");
  a_ignore_foreign: assert property (
    (eval_en && !addr_ok) |=> (st_q == modbus_pkg::ST_COLLECT) [*2])
    else $error("foreign frame answered");
  a_reply_start: assert property (
    go_send |=> tx_valid && tx_byte == slave_q)
    else $error("reply does not open with own address");
  a_func_only: assert property (
    tx_valid && idx_q == `MB_POS_FUNC |-> tx_byte == `MB_FUNC_READ_HOLD)
    else $error("reply function code wrong");
  a_reply_len: assert property (
    go_send |=> len_q == `MB_OVH_LEN + 7'({$past(q_qty), 1'b0}))
    else $error("reply length does not match quantity");
  a_crc_append: assert property (
    tx_valid && idx_q == len_q - `MB_CRC_LEN |-> tx_byte == tx_crc_q[7:0])
    else $error("crc low byte not appended");
  a_tx_in_reply: assert property (
    o_tx_en |-> st_q == modbus_pkg::ST_SEND)
    else $error("line driven outside a reply");

  c_reply:   cover property (stat_set[`MB_ST_DONE]);
  c_crc_err: cover property (stat_set[`MB_ST_CRC]);
  c_reject:  cover property (stat_set[`MB_ST_REJ]);
  c_frm_err: cover property (stat_set[`MB_ST_FRM]);
endmodule // modbus_rtu_slave_link
`default_nettype wire

// File: sim/modbus_master_model.sv
// serial master model on the far side of the rtu slave link
`timescale 1ns/1ps
`default_nettype none
module modbus_master_model (
  input  wire logic i_clk,
  input  wire logic i_txd,
  input  wire logic i_tx_en,
  output logic      o_rxd
);
  // ----------------------------------------------------------------
  // character format, set by the bench to match the slave's ctrl
  // ----------------------------------------------------------------
  int unsigned bit_clks = 16;
  logic [1:0]  par      = 2'h2;
  logic        stop2    = 1'b0;
  logic [7:0]  rxq[$];
  int          rx_bad   = 0;
  initial o_rxd = 1'b1;
  function automatic logic par_bit(input logic [7:0] b);
    return (par == 2'h1) ? ~^b : ^b;
  endfunction
  task automatic clks(input int unsigned n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic hold_bit(input logic v);
    o_rxd <= v;
    clks(bit_clks);
  endtask
  // start, eight data bits lsb first, optional parity, stop bits
  task automatic send_byte(input logic [7:0] b);
    hold_bit(1'b0);
    for (int i = 0; i < 8; i++) hold_bit(b[i]);
    if (par != 2'h0) hold_bit(par_bit(b));
    hold_bit(1'b1);
    if (stop2) hold_bit(1'b1);
  endtask
  // reply capture, sampled mid-bit; only while the slave drives the line
  always begin : rx_capture
    logic [7:0] d;
    @(posedge i_clk);
    if (i_tx_en && !i_txd) begin
      clks(bit_clks / 2);
      for (int i = 0; i < 8; i++) begin
        clks(bit_clks);
        d[i] = i_txd;
      end
      if (par != 2'h0) begin
        clks(bit_clks);
        if (i_txd !== par_bit(d)) rx_bad++;
      end
      clks(bit_clks);
      if (i_txd !== 1'b1) rx_bad++;
      rxq.push_back(d);
    end
  end
endmodule // modbus_master_model
`default_nettype wire

// File: sim/tb.sv
// self-checking bench of the modbus rtu slave link
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        i_clk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic [3:0]  i_addr = 4'h0;
  logic [15:0] i_wdata = 16'h0, o_rdata, ctrl;
  logic        o_irq, rxd, o_txd, o_tx_en;
  logic [31:0] seed = 32'hf905e33e;
  logic [15:0] hold[4];
  logic [7:0]  q[$], e[$];
  int          err_total = 0, tests_run = 0;
  always #2 i_clk = ~i_clk;
  modbus_rtu_slave_link #(.DIV_LO(16'h18), .DIV_HI(16'h10)) i_dut (.i_clk(i_clk),
    .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_irq(o_irq), .i_rxd(rxd), .o_txd(o_txd), .o_tx_en(o_tx_en));
  modbus_master_model i_mst (.i_clk(i_clk), .i_txd(o_txd), .i_tx_en(o_tx_en), .o_rxd(rxd));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic [15:0] crc(input logic [7:0] b[$]);
    logic [15:0] c = 16'hffff;
    foreach (b[i]) begin
      c ^= {8'h00, b[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    return c;
  endfunction
  task automatic final_report();
    $display("mismatches %0d checks %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] x);
    tests_run++;
    if (g !== x) begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] x);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    chk(o_rdata, x);
  endtask
  // crc appended low byte first; bad flips one bit of it
  task automatic query(input logic [7:0] a, f, input logic [15:0] s, n, input logic bad);
    logic [15:0] c;
    q = {a, f, s[15:8], s[7:0], n[15:8], n[7:0]};
    c = crc(q) ^ {15'h0, bad};
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    i_mst.rxq.delete();
    @(posedge i_clk);
    foreach (q[i]) i_mst.send_byte(q[i]);
  endtask
  // silence for longer than gap plus eval; then status flags
  task automatic no_reply(input logic [7:0] a, f, input logic [15:0] s, n, input logic bad,
                          input logic [15:0] st);
    query(a, f, s, n, bad);
    // scaled stand-in for the pause before the next slave
    repeat (3000) @(posedge i_clk);
    chk(16'(i_mst.rxq.size()), 16'h0000);
    chk({15'h0, o_irq}, 16'h0000);
    rd(4'h2, st);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    int t;
    logic [15:0] s;
    logic [15:0] ec;
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd(4'h0, 16'h000b);
    rd(4'h1, 16'h0001);
    rd(4'h3, 16'h0000);
    rd(4'h2, 16'h0000);
    wr(4'h4, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      hold[i] = seed[15:0];
      wr(4'h5, hold[i]);
    end
    wr(4'h9, 16'hffff);
    rd(4'h9, 16'h0000);
    rd(4'h4, 16'h0004);
    wr(4'h4, 16'h0001);
    rd(4'h5, hold[1]);
    rd(4'h6, 16'h0000);
    wr(4'h3, 16'h0001);
    for (int m = 0; m < 3; m++) begin
      ctrl = (m == 0) ? 16'h0001 : (m == 1) ? 16'h0017 : 16'h000b;
      wr(4'h0, ctrl);
      i_mst.par = ctrl[3:2];
      i_mst.stop2 = ctrl[4];
      i_mst.bit_clks = ctrl[1] ? 16 : 24;
      seed = xs(seed);
      s = {14'h0, seed[1:0]} % 16'h3;
      e = {8'h01, 8'h03, 8'h04, hold[s][15:8], hold[s][7:0], hold[s+1][15:8], hold[s+1][7:0]};
      ec = crc(e);
      e.push_back(ec[7:0]);
      e.push_back(ec[15:8]);
      // first try plus three retries, each waiting for the reply
      for (int r = 0; r < 4 && !o_irq; r++) begin
        query(8'h01, 8'h03, s, 16'h0002, 1'b0);
        t = 0;
        while (!o_irq && t < 8000) begin
          @(posedge i_clk);
          t++;
        end
      end
      if (!o_irq) begin
        chk(16'hdead, 16'h0000);
        final_report();
      end
      chk(16'(i_mst.rxq.size()), 16'h0009);
      foreach (e[i]) chk({8'h0, i_mst.rxq[i]}, {8'h0, e[i]});
      chk(16'(i_mst.rx_bad), 16'h0000);
      rd(4'h2, 16'h0001);
      chk({15'h0, o_irq}, 16'h0000);
    end
    no_reply(8'h01, 8'h03, 16'h0000, 16'h0002, 1'b1, 16'h0002);
    no_reply(8'h05, 8'h03, 16'h0000, 16'h0002, 1'b0, 16'h0000);
    no_reply(8'h01, 8'h04, 16'h0000, 16'h0002, 1'b0, 16'h0008);
    no_reply(8'h01, 8'h03, 16'h001f, 16'h0002, 1'b0, 16'h0008);
    // wrong parity on every character: frame flag only
    i_mst.par = 2'h1;
    no_reply(8'h01, 8'h03, 16'h0000, 16'h0002, 1'b0, 16'h0004);
    i_mst.par = 2'h2;
    // link disabled: silent, no flags
    wr(4'h0, 16'h000a);
    no_reply(8'h01, 8'h03, 16'h0000, 16'h0002, 1'b0, 16'h0000);
    final_report();
  end
endmodule // tb
`default_nettype wire
